/* frc_pkg.sv */
`default_nettype none
package frc_pkg;
    // Register map (byte addresses, one word each)
    localparam logic [7:0] ADDR_RESPONSE = 8'h00;
    localparam logic [7:0] ADDR_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h10;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
    localparam logic [7:0] ADDR_UNIT = 8'h18;

    // Response byte fields
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;
    localparam logic [7:0] RESPONSE_RESET = 8'h00;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // Response modes
    typedef enum logic [1:0] {
        MODE_IGNORE = 2'h0,
        MODE_DELAYED = 2'h1,
        MODE_SHUTDOWN = 2'h2,
        MODE_PERSIST = 2'h3
    } frc_mode_e;

    // Control register bits
    localparam int CTL_CLEAR_FAULTS = 0;
    localparam int CTL_CLEAR_LATCH = 1;
    localparam int CTL_OPERATION_ON = 2;

    // Interrupt event bits
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_SHUTDOWN = 1;
    localparam int IRQ_RETRY = 2;
    localparam int IRQ_LATCHED = 3;
    localparam int IRQ_WIDTH = 4;

    // Delay time unit: 1 ms default at 40 MHz
    localparam int CLOCK_HZ = 40000000;
    localparam int UNIT_US = 1000;
    localparam int UNIT_CYCLES = (CLOCK_HZ / 1000000) * UNIT_US;
    localparam logic [31:0] UNIT_RESET = 32'(UNIT_CYCLES);

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } frc_bus_s;
endpackage : frc_pkg
`default_nettype wire

/* frc_fault_response.sv */
`default_nettype none
module frc_fault_response #(
    parameter int UNIT_CYCLES = frc_pkg::UNIT_CYCLES
) (
    input wire logic core_clk, // System clock, 40 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire frc_pkg::frc_bus_s bus, // Register access request
    output logic [31:0] rdata, // Read data, cycle after read
    input wire logic faultPin, // Undervoltage comparator, async
    input wire logic remoteOn, // Remote control pin, async, high = on
    output logic outputEnable, // Enable to power stage
    output logic faultLatched, // Output latched off by fault
    output logic irq // Level interrupt
);
    typedef enum logic [4:0] {
        ST_OFF = 5'b00001,
        ST_RUN = 5'b00010,
        ST_DELAY = 5'b00100,
        ST_WAIT = 5'b01000,
        ST_LATCH = 5'b10000
    } frc_state_e;

    // Delay code to unit count, power of two
    function automatic logic [7:0] unitCount(input logic [2:0] code);
        unitCount = 8'h01 << code;
    endfunction : unitCount

    localparam int IRQ_W = frc_pkg::IRQ_WIDTH;

    // Host-visible configuration
    logic [7:0] response_q;
    logic [31:0] unit_q;
    logic operationOn_q;
    logic [IRQ_W-1:0] irqStatus_q;
    logic [IRQ_W-1:0] irqEnable_q;

    // Sequencer state and attempt bookkeeping
    frc_state_e state_q;
    logic [2:0] attempts_q;

    // Delay timer, split so one unit register serves every code
    logic [31:0] tick_q;
    logic [7:0] units_q;

    // Pin synchronisers and edge history
    logic [1:0] faultSync_q;
    logic [1:0] remoteSync_q;
    logic enabled_q;
    logic outputEnable_q;

    // Synchronised pin levels; nothing reads the first stage directly
    wire logic fault = faultSync_q[1];
    wire logic commandedOn = remoteSync_q[1] && operationOn_q;

    // Response byte fields
    wire frc_pkg::frc_mode_e mode = frc_pkg::frc_mode_e'(response_q[frc_pkg::MODE_HI:frc_pkg::MODE_LO]);
    wire logic [2:0] retryCode = response_q[frc_pkg::RETRY_HI:frc_pkg::RETRY_LO];
    wire logic [2:0] delayCode = response_q[frc_pkg::DELAY_HI:frc_pkg::DELAY_LO];

    // Host strobes decoded once
    wire logic wrCtl = bus.wr && bus.addr == frc_pkg::ADDR_CONTROL;
    wire logic wrIrqClear = bus.wr && bus.addr == frc_pkg::ADDR_IRQ_CLEAR;
    wire logic clearReq = wrCtl && (bus.wdata[frc_pkg::CTL_CLEAR_FAULTS] || bus.wdata[frc_pkg::CTL_CLEAR_LATCH]);

    // Off-then-on of the combined command restarts the sequencer
    wire logic offToOn = commandedOn && !enabled_q;

    // Timer idle means both counters have run out
    wire logic timerDone = units_q == 8'h00 && tick_q == 32'h0;

    // Limited codes count attempts; the top code never runs out
    wire logic retriesLeft = retryCode == frc_pkg::RETRY_FOREVER || attempts_q < retryCode;

    // Events for the interrupt block
    logic evFault;
    logic evShutdown;
    logic evRetry;
    logic evLatched;
    logic evRunFault;
    logic timerLoad;
    logic [IRQ_W-1:0] irqSet;
    logic [IRQ_W-1:0] irqClr;
    logic [31:0] statusWord;

    // Pin synchronisers; faults and remote pin are asynchronous
    // Two stages keep a metastable first stage away from the sequencer
    always_ff @(posedge core_clk) begin
        if (rst) begin
            faultSync_q <= 2'h0;
            remoteSync_q <= 2'h0;
        end else begin
            faultSync_q <= {faultSync_q[0], faultPin};
            remoteSync_q <= {remoteSync_q[0], remoteOn};
        end
    end

    // Software registers
    // Status and interrupt status are read-only here
    // Writes to clear and unmapped addresses fall through
    always_ff @(posedge core_clk) begin
        if (rst) begin
            response_q <= frc_pkg::RESPONSE_RESET;
            unit_q <= 32'(UNIT_CYCLES);
            operationOn_q <= 1'b1;
            irqEnable_q <= '0;
        end else if (bus.wr) begin
            if (bus.addr == frc_pkg::ADDR_RESPONSE) begin
                response_q <= bus.wdata[7:0];
            end else if (bus.addr == frc_pkg::ADDR_CONTROL) begin
                operationOn_q <= bus.wdata[frc_pkg::CTL_OPERATION_ON];
            end else if (bus.addr == frc_pkg::ADDR_IRQ_ENABLE) begin
                irqEnable_q <= bus.wdata[IRQ_W-1:0];
            end else if (bus.addr == frc_pkg::ADDR_UNIT) begin
                unit_q <= (bus.wdata == 32'h0) ? 32'h1 : bus.wdata; // Zero unit would stall timer
            end
        end
    end

    // Read data, one cycle after strobe; unmapped reads zero
    // Reads have no side effects, so sticky bits survive a poll
    // Write-only clear register reads as zero too
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata <= 32'h0;
        end else if (bus.rd) begin
            if (bus.addr == frc_pkg::ADDR_RESPONSE) begin
                rdata <= {24'h0, response_q};
            end else if (bus.addr == frc_pkg::ADDR_CONTROL) begin
                rdata <= {29'h0, operationOn_q, 2'h0};
            end else if (bus.addr == frc_pkg::ADDR_STATUS) begin
                rdata <= statusWord;
            end else if (bus.addr == frc_pkg::ADDR_IRQ_STATUS) begin
                rdata <= {28'h0, irqStatus_q};
            end else if (bus.addr == frc_pkg::ADDR_IRQ_ENABLE) begin
                rdata <= {28'h0, irqEnable_q};
            end else if (bus.addr == frc_pkg::ADDR_UNIT) begin
                rdata <= unit_q;
            end else begin
                rdata <= 32'h0;
            end
        end else begin
            rdata <= 32'h0;
        end
    end

    // Previous commanded-on level, for off-then-on detection
    // Reset low, so a pin already high at release reads as a turn-on
    always_ff @(posedge core_clk) begin
        if (rst) begin
            enabled_q <= 1'b0;
        end else begin
            enabled_q <= commandedOn;
        end
    end

    // Delay timer: units_q whole units plus tick_q cycles left
    // A fresh load wins over the countdown, so a retry never inherits old time
    // Limitation: the longest interval is 128 units of the unit register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tick_q <= 32'h0;
            units_q <= 8'h00;
        end else if (timerLoad) begin
            tick_q <= unit_q - 32'h1;
            units_q <= unitCount(delayCode) - 8'h1;
        end else if (tick_q != 32'h0) begin
            tick_q <= tick_q - 32'h1;
        end else if (units_q != 8'h00) begin
            units_q <= units_q - 8'h1;
            tick_q <= unit_q - 32'h1;
        end
    end

    // Sequencer
    // Commanded off wins over every state and clears the attempt count
    // Attempts count toward the limit until a clear or off-then-on
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= ST_OFF;
            attempts_q <= 3'h0;
        end else if (!commandedOn) begin
            state_q <= ST_OFF;
            attempts_q <= 3'h0;
        end else begin
            case (state_q)
                // Commanded on: start running with a fresh attempt count
                ST_OFF: begin
                    state_q <= ST_RUN;
                    attempts_q <= 3'h0;
                end
                // Running: the response mode picks what a fault does
                ST_RUN: begin
                    if (fault) begin
                        case (mode)
                            frc_pkg::MODE_IGNORE: begin
                                state_q <= ST_RUN;
                            end
                            frc_pkg::MODE_DELAYED: begin
                                state_q <= ST_DELAY;
                            end
                            frc_pkg::MODE_SHUTDOWN: begin
                                state_q <= ST_WAIT;
                            end
                            default: begin
                                state_q <= ST_WAIT; // Persist: off while fault stays
                            end
                        endcase
                    end
                end
                // Grace interval: output stays on, fault watched each cycle
                ST_DELAY: begin
                    // A vanished fault cancels the pending response
                    if (!fault) begin
                        state_q <= ST_RUN;
                    end else if (timerDone) begin
                        state_q <= (retryCode == frc_pkg::RETRY_NONE) ? ST_LATCH : ST_WAIT;
                    end
                end
                // Output off; persist waits for the fault to clear, others latch at once with no retries or wait for the timer
                ST_WAIT: begin
                    if (mode == frc_pkg::MODE_PERSIST) begin
                        if (!fault) begin
                            state_q <= ST_RUN;
                        end
                    end else if (retryCode == frc_pkg::RETRY_NONE) begin
                        state_q <= ST_LATCH;
                    end else if (timerDone) begin
                        // Interval over: try again or give up
                        if (retriesLeft) begin
                            state_q <= ST_RUN; // restart attempt
                            if (retryCode != frc_pkg::RETRY_FOREVER) begin
                                attempts_q <= attempts_q + 3'h1;
                            end
                        end else begin
                            state_q <= ST_LATCH;
                        end
                    end
                end
                // Latched off until the host clears it; the pin path goes through off
                ST_LATCH: begin
                    if (clearReq || offToOn) begin
                        state_q <= ST_RUN;
                        attempts_q <= 3'h0;
                    end
                end
                default: state_q <= ST_OFF;
            endcase
        end
    end

    // A fault-free run leaves the attempt count alone; only a retry, a clear or an off changes the count
    // Fault seen while running, in any mode
    assign evRunFault = state_q == ST_RUN && fault;

    // Delayed mode starts its grace interval
    assign evFault = evRunFault && mode == frc_pkg::MODE_DELAYED;

    // Shutdown and persist modes drop the output at once
    assign evShutdown = evRunFault && mode != frc_pkg::MODE_IGNORE && mode != frc_pkg::MODE_DELAYED;

    // Grace interval ran out with the fault still there and retries allowed
    assign evRetry = state_q == ST_DELAY && fault && timerDone && retryCode != frc_pkg::RETRY_NONE;

    // Latch off from the wait path or straight from the delay path, so
    // software sees the event whichever way the output was latched
    assign evLatched = (state_q == ST_WAIT && mode != frc_pkg::MODE_PERSIST
        && (retryCode == frc_pkg::RETRY_NONE || (timerDone && !retriesLeft)))
        || (state_q == ST_DELAY && fault && timerDone && retryCode == frc_pkg::RETRY_NONE);

    // Timer restarts on entry to a delay or a shutdown wait; persist needs none
    assign timerLoad = evFault || evRetry || (evRunFault && mode == frc_pkg::MODE_SHUTDOWN);

    // Sticky event set and host clear, same bit layout
    assign irqSet = {evLatched, evRetry, evShutdown, evRunFault};
    assign irqClr = wrIrqClear ? bus.wdata[IRQ_W-1:0] : '0;

    // Status word: attempts, one-hot state, fault, enable, latched
    assign statusWord = {
        21'h0,
        attempts_q,
        state_q,
        fault,
        outputEnable_q,
        state_q == ST_LATCH
    };

    // Output drive; off in wait and latch states
    // Enable drops at the edge that ends the cycle the shutdown event is seen, with the move to wait
    always_ff @(posedge core_clk) begin
        if (rst) begin
            outputEnable_q <= 1'b0;
        end else begin
            outputEnable_q <= commandedOn && (state_q == ST_RUN || state_q == ST_DELAY) && !evShutdown;
        end
    end
    // Port copy of the enable flop
    assign outputEnable = outputEnable_q;

    // Latched flag follows the state one edge later, like the enable
    always_ff @(posedge core_clk) begin
        if (rst) begin
            faultLatched <= 1'b0;
        end else begin
            faultLatched <= state_q == ST_LATCH;
        end
    end

    // Sticky events; a set in the clear cycle wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irqStatus_q <= '0;
        end else begin
            irqStatus_q <= (irqStatus_q & ~irqClr) | irqSet;
        end
    end

    // Level interrupt from enabled sticky bits
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus_q & irqEnable_q);
        end
    end
endmodule : frc_fault_response
`default_nettype wire

/* frc_fault_response_props.sv */
`default_nettype none
module frc_fault_response_props (
    input wire logic core_clk, // Clock
    input wire logic rst, // Sync reset
    input wire frc_pkg::frc_bus_s bus, // Register request
    input wire logic [31:0] rdata, // Read data
    input wire logic remoteOn, // Remote pin
    input wire logic outputEnable, // Stage enable
    input wire logic faultLatched, // Latched off
    input wire logic irq // Interrupt
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // Latch with the remote pin steady and no host write in flight
    sequence s_steady;
        remoteOn [*4] ##0 (faultLatched && !bus.wr && !$past(bus.wr) && !$past(bus.wr, 2));
    endsequence
    sequence s_remoteLow;
        !remoteOn [*5];
    endsequence
    property p_rstQuiet;
        disable iff (1'b0) rst |=> (!outputEnable && !faultLatched && !irq && rdata == 32'h0);
    endproperty
    property p_latchOff;
        faultLatched && $past(faultLatched) |-> !outputEnable;
    endproperty
    property p_latchHold;
        s_steady |=> faultLatched;
    endproperty
    property p_remoteOff;
        s_remoteLow |=> !outputEnable;
    endproperty
    property p_irqMask;
        bus.wr && bus.addr == frc_pkg::ADDR_IRQ_ENABLE && bus.wdata[3:0] == 4'h0 |-> ##2 !irq;
    endproperty
    property p_unmapped;
        bus.rd && bus.addr == 8'h1c |=> rdata == 32'h0;
    endproperty
    property p_respUpper;
        bus.rd && bus.addr == frc_pkg::ADDR_RESPONSE |=> rdata[31:8] == 24'h0;
    endproperty
    property p_clearLatch;
        bus.wr && bus.addr == frc_pkg::ADDR_CONTROL && bus.wdata[1] |-> ##[1:2] !faultLatched;
    endproperty
    a_rstQuiet: assert property (p_rstQuiet) else $error("outputs not quiet after reset");
    a_latchOff: assert property (p_latchOff) else $error("output on while latched");
    a_latchHold: assert property (p_latchHold) else $error("latch dropped without clear");
    a_remoteOff: assert property (p_remoteOff) else $error("output on with remote off");
    a_irqMask: assert property (p_irqMask) else $error("interrupt not masked");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_respUpper: assert property (p_respUpper) else $error("response upper bits set");
    a_clearLatch: assert property (p_clearLatch) else $error("latch clear ignored");
endmodule : frc_fault_response_props

bind frc_fault_response frc_fault_response_props u_props (.core_clk(core_clk), .rst(rst), .bus(bus),
    .rdata(rdata), .remoteOn(remoteOn), .outputEnable(outputEnable), .faultLatched(faultLatched), .irq(irq));
`default_nettype wire

/* frc_stage_model.sv */
`default_nettype none
module frc_stage_model (
    input wire logic outputEnable, // Stage enable from sequencer
    input wire logic [1:0] loadKind, // 0 healthy, 1 stuck low, 2 sags when on
    output logic faultPin // Undervoltage flag
);
    timeunit 1ns;
    timeprecision 1ps;
    // A sagging load only shows undervoltage while the stage drives it
    assign faultPin = (loadKind == 2'h1) || (loadKind == 2'h2 && outputEnable);
endmodule : frc_stage_model
`default_nettype wire

/* frc_fault_response_bench.sv */
`default_nettype none
module frc_fault_response_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    frc_pkg::frc_bus_s bus = '0;
    logic remoteOn = 1'b1;
    logic [1:0] loadKind = 2'h0;
    logic [31:0] rdata;
    logic [31:0] got;
    logic faultPin;
    logic outputEnable;
    logic faultLatched;
    logic irq;
    logic prevOe;
    int bad_count = 0;
    int n_compared = 0;
    int rises;
    int gap;
    int last;
    int cyc;
    // Clock, 25 ns period
    always #12.5 core_clk = ~core_clk;
    frc_fault_response dut (.core_clk(core_clk), .rst(rst), .bus(bus), .rdata(rdata), .faultPin(faultPin),
        .remoteOn(remoteOn), .outputEnable(outputEnable), .faultLatched(faultLatched), .irq(irq));
    frc_stage_model stage (.outputEnable(outputEnable), .loadKind(loadKind), .faultPin(faultPin));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task print_verdict;
        $display("compared=%0d mismatches=%0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task cycles(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cycles
    task setLoad(input logic [1:0] k);
        @(posedge core_clk);
        loadKind <= k;
    endtask : setLoad
    task setRemote(input logic v);
        @(posedge core_clk);
        remoteOn <= v;
    endtask : setRemote
    // Bounded wait; a hang ends the run
    task waitOe(input logic v, input int lim);
        cyc = 0;
        while (outputEnable !== v && cyc < lim) begin
            @(posedge core_clk);
            #1;
            cyc++;
        end
        chk(32'(outputEnable), 32'(v));
        if (outputEnable !== v) begin
            print_verdict();
        end
    endtask : waitOe
    // Count restart attempts and the spacing of the last two
    task countRises(input int lim);
        rises = 0;
        gap = 0;
        prevOe = outputEnable;
        for (int i = 1; i <= lim; i++) begin
            @(posedge core_clk);
            #1;
            if (outputEnable && !prevOe) begin
                gap = i - last;
                last = i;
                rises++;
            end
            prevOe = outputEnable;
        end
    endtask : countRises
    // Main sequence
    initial begin
        cycles(4);
        rst <= 1'b0;
        rd(frc_pkg::ADDR_RESPONSE, got);
        chk(got, {24'h0, frc_pkg::RESPONSE_RESET});
        rd(8'h1c, got);
        chk(got, 32'h0);
        wr(frc_pkg::ADDR_UNIT, 32'h4);
        wr(frc_pkg::ADDR_IRQ_ENABLE, 32'hf);
        waitOe(1'b1, 50);
        setLoad(2'h1);
        countRises(150);
        chk(32'(rises), 32'h0);
        chk(32'(outputEnable), 32'h1);
        setLoad(2'h0);
        wr(frc_pkg::ADDR_RESPONSE, 32'h43);
        setLoad(2'h1);
        cycles(10);
        setLoad(2'h0);
        cycles(100);
        chk(32'(outputEnable), 32'h1);
        chk(32'(faultLatched), 32'h0);
        setLoad(2'h1);
        cycles(20);
        chk(32'(outputEnable), 32'h1);
        waitOe(1'b0, 25);
        cycles(100);
        chk(32'(faultLatched), 32'h1);
        chk(32'(irq), 32'h1);
        rd(frc_pkg::ADDR_IRQ_STATUS, got);
        chk(32'(got[3]), 32'h1);
        wr(frc_pkg::ADDR_IRQ_ENABLE, 32'h0);
        setLoad(2'h0);
        wr(frc_pkg::ADDR_CONTROL, 32'h7);
        waitOe(1'b1, 20);
        wr(frc_pkg::ADDR_IRQ_CLEAR, 32'hf);
        wr(frc_pkg::ADDR_IRQ_ENABLE, 32'hf);
        cycles(3);
        chk(32'(irq), 32'h0);
        // Each limited retry code, delay code 1 is 8 cycles
        for (int n = 0; n < 7; n++) begin
            wr(frc_pkg::ADDR_RESPONSE, 32'h81 | (32'(n) << 3));
            setLoad(2'h2);
            waitOe(1'b0, 6);
            countRises(300);
            chk(32'(rises), 32'(n));
            chk(32'(faultLatched), 32'h1);
            if (n > 1) begin
                chk(32'(gap >= 8 && gap <= 16), 32'h1);
            end
            setLoad(2'h0);
            if (n % 2 == 1) begin
                wr(frc_pkg::ADDR_CONTROL, 32'h7);
            end else begin
                setRemote(1'b0);
                cycles(8);
                setRemote(1'b1);
            end
            waitOe(1'b1, 30);
        end
        wr(frc_pkg::ADDR_RESPONSE, 32'hc0);
        setLoad(2'h1);
        waitOe(1'b0, 10);
        setLoad(2'h0);
        waitOe(1'b1, 20);
        wr(frc_pkg::ADDR_RESPONSE, 32'hb9);
        setLoad(2'h2);
        countRises(300);
        chk(32'(rises >= 15), 32'h1);
        chk(32'(faultLatched), 32'h0);
        setRemote(1'b0);
        cycles(8);
        chk(32'(outputEnable), 32'h0);
        setLoad(2'h0);
        setRemote(1'b1);
        waitOe(1'b1, 30);
        print_verdict();
    end
endmodule : frc_fault_response_bench
`default_nettype wire
